// ---- rtl/ncd_pkg.sv ----
package ncd_pkg;

	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int INSTR_W   = 16;
	localparam int PC_W      = 11;
	localparam int NIB_W     = 4;
	localparam int ROW_W     = 3;
	localparam int COL_W     = 4;
	localparam int MADDR_W   = ROW_W + COL_W;
	localparam int MEM_DEPTH = 2 ** MADDR_W;
	localparam int PADDR_W   = 7;
	localparam int DBF_W     = 16;
	localparam int RADDR_W   = 4;
	localparam int RDATA_W   = 16;

	// ==========================================================================
	// Instruction fields and op codes
	// ==========================================================================
	localparam int OP_MSB  = 15;
	localparam int OP_LSB  = 11;
	localparam int ROW_MSB = 10;
	localparam int ROW_LSB = 8;
	localparam int COL_MSB = 7;
	localparam int COL_LSB = 4;
	localparam int LOW_MSB = 3;
	localparam int FORM_BIT = 15;

	localparam logic [4:0] OP_ADD_RM   = 5'h00;
	localparam logic [4:0] OP_SYS      = 5'h07;
	localparam logic [4:0] OP_LD       = 5'h08;
	localparam logic [4:0] OP_SKE      = 5'h09;
	localparam logic [4:0] OP_MOV_TOI  = 5'h0A;
	localparam logic [4:0] OP_UNEQUAL_SKIP     = 5'h0B;
	localparam logic [4:0] OP_BR       = 5'h0C;
	localparam logic [4:0] OP_ST       = 5'h18;
	localparam logic [4:0] OP_NO_BORROW_SKIP     = 5'h19;
	localparam logic [4:0] OP_MOV_FRI  = 5'h1A;
	localparam logic [4:0] OP_BORROW_SKIP     = 5'h1B;
	localparam logic [4:0] OP_CALL     = 5'h1C;
	localparam logic [4:0] OP_MOV_IMM  = 5'h1D;
	localparam logic [4:0] OP_SKT      = 5'h1E;
	localparam logic [4:0] OP_SKF      = 5'h1F;

	localparam logic [3:0] ALU_ADD  = 4'h0;
	localparam logic [3:0] ALU_SUB  = 4'h1;
	localparam logic [3:0] ALU_ADD_WITH_CARRY = 4'h2;
	localparam logic [3:0] ALU_SUBTRACT_WITH_BORROW = 4'h3;
	localparam logic [3:0] ALU_AND  = 4'h4;
	localparam logic [3:0] ALU_XOR  = 4'h5;
	localparam logic [3:0] ALU_OR   = 4'h6;

	localparam logic [3:0] COL_ROTATE_RIGHT_VIA_CARRY = 4'h7;
	localparam logic [3:0] COL_PUT  = 4'hA;
	localparam logic [3:0] COL_GET  = 4'hB;
	localparam logic [3:0] COL_RET  = 4'hE;
	localparam logic [3:0] COL_CTL  = 4'hF;
	localparam logic [2:0] HI_ROTATE_RIGHT_VIA_CARRY  = 3'h0;
	localparam logic [2:0] HI_RET   = 3'h0;
	localparam logic [2:0] HI_SUBROUTINE_EXIT_SKIP = 3'h1;
	localparam logic [2:0] HI_STOP  = 3'h2;
	localparam logic [2:0] HI_HALT  = 3'h3;

	localparam logic [2:0] GREG_ROW = 3'h0;
	localparam logic [10:0] PC_RESET = 11'h000;

	// ==========================================================================
	// Software register map
	// ==========================================================================
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h1;
	localparam logic [3:0] REG_PC      = 4'h2;
	localparam logic [3:0] REG_DBF     = 4'h3;
	localparam logic [3:0] REG_MEMPTR  = 4'h4;
	localparam logic [3:0] REG_MEMDATA = 4'h5;
	localparam logic [3:0] REG_STACK   = 4'h6;
	localparam int CTRL_RUN_BIT = 0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_GET,
		ST_GETCAP,
		ST_STOP,
		ST_HALT
	} ncd_state_e;

endpackage

// ---- rtl/ncd_decoder.sv ----
`timescale 1ns/1ns
module ncd_decoder
	import ncd_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	output logic [ncd_pkg::PC_W-1:0]           imem_addr,
	output logic                               imem_rd,
	input  wire logic [ncd_pkg::INSTR_W-1:0]   imem_data,
	output logic [ncd_pkg::PADDR_W-1:0]        periph_addr,
	output logic [ncd_pkg::DBF_W-1:0]          periph_wdata,
	output logic                               periph_we,
	output logic                               periph_re,
	input  wire logic [ncd_pkg::DBF_W-1:0]     periph_rdata,
	input  wire logic [ncd_pkg::NIB_W-1:0]     wake_pins,
	output logic                               core_stopped,
	output logic                               core_halted,
	input  wire logic [ncd_pkg::RADDR_W-1:0]   reg_addr,
	input  wire logic [ncd_pkg::RDATA_W-1:0]   reg_wdata,
	input  wire logic                          reg_we,
	input  wire logic                          reg_re,
	output logic [ncd_pkg::RDATA_W-1:0]        reg_rdata
);
	import ncd_pkg::*;

	// ==========================================================================
	// State
	// ==========================================================================
	ncd_state_e             state_reg;
	ncd_state_e             state_next;
	logic [PC_W-1:0]        pc_reg;
	logic [PC_W-1:0]        pc_next;
	logic [PC_W-1:0]        stack_reg;
	logic [NIB_W-1:0]       mem_reg [MEM_DEPTH];
	logic                   carry_reg;
	logic                   cmp_reg;
	logic                   skip_reg;
	logic                   run_reg;
	logic [DBF_W-1:0]       dbf_reg;
	logic [NIB_W-1:0]       release_reg;
	logic [MADDR_W-1:0]     memptr_reg;
	logic [NIB_W-1:0]       wake_meta_reg;
	logic [NIB_W-1:0]       wake_sync_reg;
	logic [PADDR_W-1:0]     periph_addr_reg;
	logic [DBF_W-1:0]       periph_wdata_reg;
	logic                   periph_we_reg;
	logic                   periph_re_reg;
	logic                   imem_rd_reg;
	logic                   stopped_reg;
	logic                   halted_reg;
	logic [RDATA_W-1:0]     rdata_reg;

	// ==========================================================================
	// Arithmetic shared by the ALU and the compare-and-skip group
	// ==========================================================================
	function automatic logic [NIB_W:0] alu_calc(
		input logic [3:0]       sel,
		input logic [NIB_W-1:0] a,
		input logic [NIB_W-1:0] b,
		input logic             cy
	);
		logic [NIB_W:0] res;
		res = {1'b0, a};
		case (sel)
			ALU_ADD:  res = {1'b0, a} + {1'b0, b};
			ALU_ADD_WITH_CARRY: res = {1'b0, a} + {1'b0, b} + (NIB_W+1)'(cy);
			ALU_SUB:  res = {1'b0, a} - {1'b0, b};
			ALU_SUBTRACT_WITH_BORROW: res = {1'b0, a} - {1'b0, b} - (NIB_W+1)'(cy);
			ALU_AND:  res = {1'b0, a & b};
			ALU_XOR:  res = {1'b0, a ^ b};
			ALU_OR:   res = {1'b0, a | b};
			default:  res = {1'b0, a};
		endcase
		return res;
	endfunction

	// ==========================================================================
	// Field decode
	// ==========================================================================
	logic [4:0]         opcode;
	logic [ROW_W-1:0]   fld_row;
	logic [COL_W-1:0]   fld_col;
	logic [NIB_W-1:0]   fld_low;
	logic [PC_W-1:0]    fld_addr;
	logic [MADDR_W-1:0] m_addr;
	logic [MADDR_W-1:0] r_addr;
	logic [MADDR_W-1:0] ind_addr;
	logic [NIB_W-1:0]   m_val;
	logic [NIB_W-1:0]   r_val;
	logic [NIB_W-1:0]   ind_val;
	logic [3:0]         alu_sel;
	logic               imm_form;
	logic               is_alu;
	logic               is_arith;
	logic               exec;
	logic               is_rotate_right_via_carry;
	logic               is_get;
	logic               is_put;
	logic               is_ret;
	logic               is_subroutine_exit_skip;
	logic               is_stop;
	logic               is_halt;
	logic               is_test;
	logic [NIB_W:0]     alu_out;
	logic [NIB_W:0]     cmp_out;
	logic               skip_cond;
	logic               released;
	logic               idle_wr;
	logic [PC_W-1:0]    pc_inc;

	assign opcode   = imem_data[OP_MSB:OP_LSB];
	assign fld_row  = imem_data[ROW_MSB:ROW_LSB];
	assign fld_col  = imem_data[COL_MSB:COL_LSB];
	assign fld_low  = imem_data[LOW_MSB:0];
	assign fld_addr = imem_data[PC_W-1:0];
	assign m_addr   = {fld_row, fld_col};
	// General registers live in one fixed row of the data memory.
	assign r_addr   = {GREG_ROW, fld_low};
	assign m_val    = mem_reg[m_addr];
	assign r_val    = mem_reg[r_addr];
	assign ind_addr = {fld_row, r_val};
	assign ind_val  = mem_reg[ind_addr];

	assign alu_sel  = imem_data[OP_MSB-1:OP_LSB];
	assign imm_form = imem_data[FORM_BIT];
	assign is_alu   = alu_sel <= ALU_OR;
	assign is_arith = alu_sel <= ALU_SUBTRACT_WITH_BORROW;
	// A skipped instruction reaches EXEC but has no effect.
	assign exec     = (state_reg == ST_EXEC) && !skip_reg;

	assign is_rotate_right_via_carry  = opcode == OP_SYS && fld_col == COL_ROTATE_RIGHT_VIA_CARRY && fld_row == HI_ROTATE_RIGHT_VIA_CARRY;
	assign is_get   = opcode == OP_SYS && fld_col == COL_GET;
	assign is_put   = opcode == OP_SYS && fld_col == COL_PUT;
	assign is_ret   = opcode == OP_SYS && fld_col == COL_RET && fld_row == HI_RET;
	assign is_subroutine_exit_skip = opcode == OP_SYS && fld_col == COL_RET && fld_row == HI_SUBROUTINE_EXIT_SKIP;
	assign is_stop  = opcode == OP_SYS && fld_col == COL_CTL && fld_row == HI_STOP;
	assign is_halt  = opcode == OP_SYS && fld_col == COL_CTL && fld_row == HI_HALT;
	assign is_test  = opcode == OP_SKT || opcode == OP_SKF;

	assign alu_out  = alu_calc(alu_sel, imm_form ? m_val : r_val, imm_form ? fld_low : m_val, carry_reg);
	assign cmp_out  = alu_calc(ALU_SUB, m_val, fld_low, 1'b0);

	assign skip_cond = (opcode == OP_SKT  && (m_val & fld_low) == fld_low)
	                || (opcode == OP_SKF  && (m_val & fld_low) == '0)
	                || (opcode == OP_SKE  && cmp_out[NIB_W-1:0] == '0)
	                || (opcode == OP_UNEQUAL_SKIP && cmp_out[NIB_W-1:0] != '0)
	                || (opcode == OP_NO_BORROW_SKIP && !cmp_out[NIB_W])
	                || (opcode == OP_BORROW_SKIP && cmp_out[NIB_W])
	                || is_subroutine_exit_skip;

	assign released = |(wake_sync_reg & release_reg);
	// Software may only change the PC, data buffer and data memory while the core is in ST_IDLE.
	assign idle_wr  = reg_we && state_reg == ST_IDLE;
	assign pc_inc   = pc_reg + PC_W'(1);

	// ==========================================================================
	// Data memory write port
	// ==========================================================================
	logic               wr_en;
	logic [MADDR_W-1:0] wr_addr;
	logic [NIB_W-1:0]   wr_data;

	always_comb
	begin
		wr_en   = 1'b0;
		wr_addr = m_addr;
		wr_data = alu_out[NIB_W-1:0];
		if (exec && is_alu)
		begin
			wr_en   = 1'b1;
			wr_addr = imm_form ? m_addr : r_addr;
		end
		else if (exec)
		begin
			case (opcode)
				OP_LD:      begin wr_en = 1'b1; wr_addr = r_addr;   wr_data = m_val;   end
				OP_ST:      begin wr_en = 1'b1; wr_addr = m_addr;   wr_data = r_val;   end
				OP_MOV_IMM: begin wr_en = 1'b1; wr_addr = m_addr;   wr_data = fld_low; end
				OP_MOV_TOI: begin wr_en = 1'b1; wr_addr = ind_addr; wr_data = m_val;   end
				OP_MOV_FRI: begin wr_en = 1'b1; wr_addr = m_addr;   wr_data = ind_val; end
				OP_SYS:
				begin
					wr_en   = is_rotate_right_via_carry;
					wr_addr = r_addr;
					wr_data = {carry_reg, r_val[NIB_W-1:1]};
				end
				default: wr_en = 1'b0;
			endcase
		end
		else if (idle_wr && reg_addr == REG_MEMDATA)
		begin
			wr_en   = 1'b1;
			wr_addr = memptr_reg;
			wr_data = reg_wdata[NIB_W-1:0];
		end
	end

	// Data memory has no reset; software initialises it like RAM.
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem_reg[wr_addr] <= wr_data;
	end

	// ==========================================================================
	// Sequencer
	// ==========================================================================
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:   state_next = run_reg ? ST_FETCH : ST_IDLE;
			ST_FETCH:  state_next = ST_EXEC;
			ST_EXEC:
			begin
				if (exec && is_get)
					state_next = ST_GET;
				else if (exec && is_stop)
					state_next = ST_STOP;
				else if (exec && is_halt)
					state_next = ST_HALT;
				else
					state_next = run_reg ? ST_FETCH : ST_IDLE;
			end
			ST_GET:    state_next = ST_GETCAP;
			ST_GETCAP: state_next = run_reg ? ST_FETCH : ST_IDLE;
			ST_STOP,
			ST_HALT:   state_next = released ? (run_reg ? ST_FETCH : ST_IDLE) : state_reg;
		endcase
	end

	always_comb
	begin
		pc_next = pc_reg;
		if (state_reg == ST_EXEC)
		begin
			pc_next = pc_inc;
			if (exec && (opcode == OP_BR || opcode == OP_CALL))
				pc_next = fld_addr;
			else if (exec && (is_ret || is_subroutine_exit_skip))
				pc_next = stack_reg;
		end
		else if (idle_wr && reg_addr == REG_PC)
			pc_next = reg_wdata[PC_W-1:0];
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= ST_IDLE;
			pc_reg    <= PC_RESET;
			stack_reg <= PC_RESET;
			skip_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pc_reg    <= pc_next;
			if (exec && opcode == OP_CALL)
				stack_reg <= pc_inc;
			if (state_reg == ST_EXEC)
				skip_reg <= exec && skip_cond;
		end
	end

	// ==========================================================================
	// Flags, data buffer and release condition
	// ==========================================================================
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			carry_reg   <= 1'b0;
			cmp_reg     <= 1'b0;
			dbf_reg     <= '0;
			release_reg <= '0;
		end
		else
		begin
			if (exec && is_alu && is_arith)
				carry_reg <= alu_out[NIB_W];
			else if (exec && is_rotate_right_via_carry)
				carry_reg <= r_val[0];
			if (exec && is_test)
				cmp_reg <= 1'b0;
			if (state_reg == ST_GETCAP)
				dbf_reg <= periph_rdata;
			else if (idle_wr && reg_addr == REG_DBF)
				dbf_reg <= reg_wdata[DBF_W-1:0];
			if (exec && (is_stop || is_halt))
				release_reg <= fld_low;
		end
	end

	// ==========================================================================
	// Port outputs and wake synchroniser
	// ==========================================================================
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wake_meta_reg    <= '0;
			wake_sync_reg    <= '0;
			imem_rd_reg      <= 1'b0;
			periph_addr_reg  <= '0;
			periph_wdata_reg <= '0;
			periph_we_reg    <= 1'b0;
			periph_re_reg    <= 1'b0;
			stopped_reg      <= 1'b0;
			halted_reg       <= 1'b0;
		end
		else
		begin
			wake_meta_reg <= wake_pins;
			wake_sync_reg <= wake_meta_reg;
			imem_rd_reg   <= state_next == ST_FETCH;
			if (exec && (is_get || is_put))
				periph_addr_reg <= {fld_row, fld_low};
			if (exec && is_put)
				periph_wdata_reg <= dbf_reg;
			periph_we_reg <= exec && is_put;
			periph_re_reg <= state_next == ST_GET;
			stopped_reg   <= state_next == ST_STOP;
			halted_reg    <= state_next == ST_HALT;
		end
	end

	assign imem_addr    = pc_reg;
	assign imem_rd      = imem_rd_reg;
	assign periph_addr  = periph_addr_reg;
	assign periph_wdata = periph_wdata_reg;
	assign periph_we    = periph_we_reg;
	assign periph_re    = periph_re_reg;
	assign core_stopped = stopped_reg;
	assign core_halted  = halted_reg;
	assign reg_rdata    = rdata_reg;

	// ==========================================================================
	// Software register port
	// ==========================================================================
	logic [RDATA_W-1:0] rd_mux;

	always_comb
	begin
		case (reg_addr)
			REG_CTRL:    rd_mux = RDATA_W'(run_reg);
			REG_STATUS:  rd_mux = RDATA_W'({state_reg != ST_IDLE, halted_reg, stopped_reg,
			                                skip_reg, cmp_reg, carry_reg});
			REG_PC:      rd_mux = RDATA_W'(pc_reg);
			REG_DBF:     rd_mux = RDATA_W'(dbf_reg);
			REG_MEMPTR:  rd_mux = RDATA_W'(memptr_reg);
			REG_MEMDATA: rd_mux = RDATA_W'(mem_reg[memptr_reg]);
			REG_STACK:   rd_mux = RDATA_W'(stack_reg);
			default:     rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			run_reg    <= 1'b0;
			memptr_reg <= '0;
			rdata_reg  <= '0;
		end
		else
		begin
			if (reg_we && reg_addr == REG_CTRL)
				run_reg <= reg_wdata[CTRL_RUN_BIT];
			if (reg_we && reg_addr == REG_MEMPTR)
				memptr_reg <= reg_wdata[MADDR_W-1:0];
			rdata_reg <= reg_re ? rd_mux : '0;
		end
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_fetch_then_exec: assert property (imem_rd |-> state_reg == ST_FETCH ##1 state_reg == ST_EXEC)
		else $error("fetch not followed by execute");
	a_jump_target: assert property (exec && opcode == OP_BR |=> pc_reg == $past(fld_addr))
		else $error("jump did not load address field");
	a_call_push: assert property (exec && opcode == OP_CALL
			|=> stack_reg == PC_W'($past(pc_reg) + 1) && pc_reg == $past(fld_addr))
		else $error("call did not push return address");
	a_ret_restore: assert property (exec && (is_ret || is_subroutine_exit_skip) |=> pc_reg == $past(stack_reg))
		else $error("return did not restore program counter");
	a_skip_is_nop: assert property (state_reg == ST_EXEC && skip_reg
			|=> !skip_reg && pc_reg == PC_W'($past(pc_reg) + 1) && !periph_we)
		else $error("skipped instruction had an effect");
	a_test_clears_cmp: assert property (exec && is_test |=> !cmp_reg)
		else $error("bit test left compare flag set");
	a_equal_skip: assert property (exec && opcode == OP_SKE && m_val == fld_low |=> skip_reg)
		else $error("equal skip did not arm skip");
	a_borrow_skip: assert property (exec && opcode == OP_BORROW_SKIP && m_val >= fld_low |=> !skip_reg)
		else $error("borrow skip taken without borrow");
	a_add_result: assert property (exec && opcode == OP_ADD_RM
			|=> mem_reg[$past(r_addr)] == NIB_W'($past(r_val) + $past(m_val)))
		else $error("register add wrote wrong sum");
	a_get_capture: assert property (periph_re |=> ##1 dbf_reg == $past(periph_rdata))
		else $error("peripheral read not captured");
	a_put_strobe: assert property (exec && is_put |=> periph_we && periph_wdata == $past(dbf_reg))
		else $error("peripheral write lost data buffer");
	a_stop_entry: assert property (exec && is_stop |=> ##1 core_stopped)
		else $error("stop state not entered");
	a_halt_entry: assert property (exec && is_halt |=> ##1 core_halted && release_reg == $past(fld_low, 2))
		else $error("halt state or release field wrong");

endmodule

// ---- verif/ncd_imem_model.sv ----
`timescale 1ns/1ns
module ncd_imem_model
	import ncd_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic [ncd_pkg::PC_W-1:0]  imem_addr,
	input  wire logic                      imem_rd,
	output logic [ncd_pkg::INSTR_W-1:0]    imem_data
);
	logic [INSTR_W-1:0] mem [0:2**PC_W-1];
	logic [INSTR_W-1:0] q;
	logic               vld;

	// Outside its answer cycle the word shows inverted, so a late sample cannot match by luck.
	assign imem_data = vld ? q : ~q;

	always @(posedge clk)
	begin
		vld <= imem_rd;
		if (imem_rd)
			q <= mem[imem_addr];
	end
endmodule

// ---- verif/test_nibble_cpu_instruction_decoder.sv ----
`timescale 1ns/1ns
module test_nibble_cpu_instruction_decoder;
	import ncd_pkg::*;
	logic        clk = 0, arst_n = 0, reg_we = 0, reg_re = 0, imem_rd, periph_we, periph_re;
	logic        core_stopped, core_halted;
	logic [3:0]  reg_addr = 0;
	logic [6:0]  periph_addr;
	logic [10:0] imem_addr;
	logic [15:0] reg_wdata = 0, periph_rdata = 0, rdv, imem_data, periph_wdata, reg_rdata;
	logic [15:0] prog [0:31];
	logic [19:0] seed = 20'h1_6df2;
	int          n_mismatch = 0, n_checks = 0, n_put, mm [128], cy, stk, dbf, pg, pp, i, j, k;
	int          ops [25] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18, 19, 20, 21, 22, 8, 24, 9, 11, 25, 27, 30, 31, 10, 26, 29};

	always #5 clk = ~clk;

	ncd_decoder dut (.clk(clk), .arst_n(arst_n), .imem_addr(imem_addr), .imem_rd(imem_rd), .imem_data(imem_data),
		.periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_we(periph_we), .periph_re(periph_re),
		.periph_rdata(periph_rdata), .wake_pins(4'h0), .core_stopped(core_stopped), .core_halted(core_halted),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
	ncd_imem_model u_imem (.clk(clk), .imem_addr(imem_addr), .imem_rd(imem_rd), .imem_data(imem_data));

	// ==========================================================================
	// Helpers
	// ==========================================================================
	function automatic int rnd();
		repeat (7) seed = {seed[18:0], seed[19] ^ seed[16]};
		return int'(seed);
	endfunction

	function automatic logic [15:0] mk(input int op);
		return 16'(op * 2048 + (rnd() % 2) * 256 + (rnd() & 255));
	endfunction

	task automatic chk(input logic ok, input string what);
		n_checks++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	task end_sim;
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task rd(input logic [3:0] a);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 rdv = reg_rdata;
	endtask

	// ==========================================================================
	// Reference model of the instruction set
	// ==========================================================================
	task automatic model();
		int pc, sk, rw, cl, lo, ma, m, r, t, a, b;
		logic [15:0] w;
		pc = 0;
		sk = 0;
		for (int n = 0; n < 100; n++)
		begin
			w = prog[pc];
			pc++;
			if (sk)
			begin
				sk = 0;
				continue;
			end
			rw = w[10:8];
			cl = w[7:4];
			lo = w[3:0];
			ma = rw * 16 + cl;
			m = mm[ma];
			r = mm[lo];
			if (!w[14] && w[13:11] != 7)
			begin
				a = w[15] ? m : r;
				b = w[15] ? lo : m;
				case (w[13:11])
					0: t = a + b;
					1: t = a - b;
					2: t = a + b + cy;
					3: t = a - b - cy;
					4: t = a & b;
					5: t = a ^ b;
					default: t = a | b;
				endcase
				if (w[13:11] < 4)
					cy = (t >> 4) & 1;
				if (w[15])
					mm[ma] = t & 15;
				else
					mm[lo] = t & 15;
			end
			else case (w[15:11])
				7: case (cl)
					7:
					begin
						mm[lo] = cy * 8 + r / 2;
						cy = r % 2;
					end
					11: dbf = periph_rdata;
					14:
					begin
						pc = stk;
						sk = rw;
					end
					15: if (rw == 2 || rw == 3) break;
				endcase
				8: mm[lo] = m;
				24: mm[ma] = r;
				10: mm[rw * 16 + r] = m;
				26: mm[ma] = mm[rw * 16 + r];
				29: mm[ma] = lo;
				9: sk = m == lo;
				11: sk = m != lo;
				25: sk = m >= lo;
				27: sk = m < lo;
				30: sk = (m & lo) == lo;
				31: sk = (m & lo) == 0;
				12: pc = w[10:0];
				28:
				begin
					stk = pc;
					pc = w[10:0];
				end
			endcase
		end
	endtask

	// ==========================================================================
	// Peripheral strobes and run sequence
	// ==========================================================================
	always @(posedge clk)
	begin
		if (periph_re === 1'b1)
			chk(periph_addr === 7'(pg), "read address");
		if (periph_we === 1'b1)
		begin
			n_put++;
			chk(periph_addr === 7'(pp) && periph_wdata === 16'(dbf), "write port");
		end
	end

	initial
	begin
		#200000;
		n_mismatch++;
		end_sim;
	end

	initial
	begin
		for (j = 0; j < 6; j++)
		begin
			@(posedge clk);
			arst_n <= 1'b0;
			periph_rdata <= 16'(rnd());
			repeat (6) @(posedge clk);
			arst_n <= 1'b1;
			for (i = 0; i < 32; i++)
			begin
				mm[i] = rnd() % 16;
				wr(REG_MEMPTR, 16'(i));
				wr(REG_MEMDATA, 16'(mm[i]));
			end
			// The first word is an add so the carry is known before any carry-using op.
			for (i = 0; i < 32; i++)
			begin
				k = rnd() % 26;
				prog[i] = (i == 0 || i > 19) ? mk(0) : (k == 25) ? 16'(14448 + rnd() % 16) : mk(ops[k]);
			end
			pg = rnd() % 128;
			pp = rnd() % 128;
			prog[20] = 16'(28 * 2048 + 30);
			prog[21] = mk(29);
			prog[22] = 16'(12 * 2048 + 25);
			prog[25] = 16'(14336 + (pg / 16) * 256 + 176 + pg % 16);
			prog[26] = 16'(14336 + (pp / 16) * 256 + 160 + pp % 16);
			// Odd runs end in halt, even runs in stop; a zero release field keeps the core parked.
			prog[27] = 16'(14336 + 752 + (j % 2) * 256);
			prog[30] = 16'(14336 + 480);
			for (i = 0; i < 32; i++)
				u_imem.mem[i] = prog[i];
			model();
			n_put = 0;
			wr(REG_CTRL, 16'h0001);
			for (i = 0; i < 1000 && core_stopped !== 1'b1 && core_halted !== 1'b1; i++)
				@(posedge clk);
			chk(core_stopped === 1'(j % 2 == 0) && core_halted === 1'(j % 2), "stop or halt state");
			rd(REG_STATUS);
			chk(rdv[0] === 1'(cy) && rdv[4] === 1'(j % 2), "carry");
			rd(REG_DBF);
			chk(rdv === 16'(dbf), "data buffer");
			for (i = 0; i < 32; i++)
			begin
				wr(REG_MEMPTR, 16'(i));
				rd(REG_MEMDATA);
				chk(rdv[3:0] === 4'(mm[i]), "memory");
			end
			chk(n_put == 1, "write count");
		end
		end_sim;
	end
endmodule
